// ==== uxr_defs.vh ====
`ifndef UXR_DEFS_VH
`define UXR_DEFS_VH

//****************************************************************
// Register offsets (plain port, word index)
//****************************************************************
`define UXR_ADDR_W          2
`define UXR_OFS_STATUS_A    2'h0
`define UXR_OFS_CONTROL_B   2'h1
`define UXR_OFS_CONTROL_C   2'h2
`define UXR_OFS_RX_DATA     2'h3

//****************************************************************
// Field positions
//****************************************************************
`define UXR_BIT_RXC         7
`define UXR_BIT_FE          4
`define UXR_BIT_DOR         3
`define UXR_BIT_UPE         2
`define UXR_BIT_DBL         1
`define UXR_BIT_EN          4
`define UXR_BIT_UPM_HI      5
`define UXR_BIT_UPM_LO      4
`define UXR_BIT_SBS         3
`define UXR_BIT_CSZ_HI      2
`define UXR_BIT_CSZ_LO      1

//****************************************************************
// Reset values
//****************************************************************
`define UXR_RST_EN          1'h0
`define UXR_RST_DBL         1'h0
`define UXR_RST_UPM         2'h0
`define UXR_RST_SBS         1'h0
`define UXR_RST_CSZ         2'h3

//****************************************************************
// Sampling counts
//****************************************************************
`define UXR_SPB_NORM        5'h10
`define UXR_SPB_DBL         5'h08
`define UXR_VOTE_NORM       5'h08
`define UXR_VOTE_DBL        5'h04
`define UXR_VOTE_SPAN       5'h02
`define UXR_MIN_BITS        4'h5
`define UXR_BUF_DEPTH       2'h2

`endif

// ==== uxr_sync.v ====
//****************************************************************
// Two-flop level synchroniser
//****************************************************************
module uxr_sync #(
   parameter RESET_VAL = 1'b1
) (
   input  wire mclk_in,
   input  wire rst_b_in,
   input  wire async_in,
   output reg  sync_out
);

   reg meta_reg;

   // Only the second flop looks at the first
   always @(posedge mclk_in) begin
      if (!rst_b_in) begin
         meta_reg <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule // uxr_sync

// ==== uxr_vote3.v ====
//****************************************************************
// Three-sample majority
//****************************************************************
module uxr_vote3 (
   input  wire [2:0] samples_in,
   output wire       high_out
);

   assign high_out = (samples_in[0] & samples_in[1]) |
                     (samples_in[0] & samples_in[2]) |
                     (samples_in[1] & samples_in[2]);

endmodule // uxr_vote3

// ==== uxr_rx_core.v ====
`include "uxr_defs.vh"

//****************************************************************
// Receiver core
//****************************************************************
// What this block does
// R1: Error flags stored with their buffered character
// R2: Software reads status before data
// R3: Writes to error flag bits ignored
// R4: Software writes zeros to error flags
// R5: Error flags raise no interrupt
// R6: Frame error reflects first stop bit
// R7: Overrun on full buffer, waiting char, start
// R8: Overrun cleared on successful buffer transfer
// R9: Parity check when upper mode bit set
// R10: Parity error per character until read
// R11: Parity error reads zero when checking off
// R12: Disable stops reception at once
// R13: Disable empties the receive buffer
// R14: Software drains buffer by reading data
// R15: Sample at sixteen or eight per bit
// R16: Start checked at samples 8-10 or 4-6
// R17: Majority high start rejected as noise
// R18: Per-bit sample state counts 16 or 8
// R19: Bit value by three-sample centre majority
// R20: Recover data, parity, first stop only
// R21: Stop bit voted, low gives frame error
// R22: New start right after stop vote, one sample later at double speed
// R23: Receive complete while buffer holds data
// R24: Serial input through two-flop synchroniser
module uxr_rx_core (
   input  wire                    mclk_in,
   input  wire                    rst_b_in,
   input  wire [`UXR_ADDR_W-1:0]  addr_in,
   input  wire [7:0]              wdata_in,
   input  wire                    wr_in,
   input  wire                    rd_in,
   input  wire                    sample_tick_in,
   input  wire                    serial_input_pin_in,
   output reg  [7:0]              rdata_out,
   output reg                     pin_override_out
);

   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_START = 2'h1;
   localparam [1:0] ST_BITS  = 2'h2;
   localparam [1:0] ST_GAP   = 2'h3;

   //*************************************************************
   // Declarations
   //*************************************************************
   wire        rx_s;
   wire        maj;
   reg         receiver_enable_reg;
   reg         double_speed_select_reg;
   reg  [1:0]  parity_mode_field_reg;
   reg         stop_bit_count_select_reg;
   reg  [1:0]  char_size_reg;

   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg  [4:0]  cnt_reg;
   reg  [4:0]  cnt_next;
   reg  [3:0]  bit_reg;
   reg  [3:0]  bit_next;
   reg  [2:0]  vote_reg;
   reg  [2:0]  vote_next;
   reg  [7:0]  shift_reg;
   reg  [7:0]  shift_next;
   reg         par_reg;
   reg         par_next;
   reg         perr_reg;
   reg         perr_next;
   reg         prev_reg;
   reg         prev_next;
   reg         done;
   reg         start_ok;
   reg         done_fe;

   reg  [7:0]  mem_data_reg [0:1];
   reg  [1:0]  mem_fe_reg;
   reg  [1:0]  mem_dor_reg;
   reg  [1:0]  mem_pe_reg;
   reg         rptr_reg;
   reg         wptr_reg;
   reg  [1:0]  fill_reg;
   reg  [1:0]  fill_next;
   reg         hold_valid_reg;
   reg         hold_valid_next;
   reg  [7:0]  hold_data_reg;
   reg  [7:0]  hold_data_next;
   reg         hold_fe_reg;
   reg         hold_fe_next;
   reg         hold_pe_reg;
   reg         hold_pe_next;
   reg         overrun_flag_reg;
   reg         overrun_flag_next;
   reg         push;
   reg  [7:0]  push_data;
   reg         push_fe;
   reg         push_pe;
   reg  [7:0]  rdata_next;

   wire [4:0]  spb;
   wire [4:0]  v_first;
   wire [4:0]  v_last;
   wire [3:0]  nbits;
   wire        in_window;
   wire        is_data;
   wire        is_par;
   wire        pop;
   wire        can_push;
   wire        has_data;
   wire        head_fe;
   wire        head_dor;
   wire        head_pe;

   //*************************************************************
   // Input conditioning
   //*************************************************************
   uxr_sync #(
      .RESET_VAL (1'b1)
   ) u_sync (
      .mclk_in   (mclk_in),
      .rst_b_in  (rst_b_in),
      .async_in  (serial_input_pin_in),
      .sync_out  (rx_s)
   ); // [R24]

   uxr_vote3 u_vote (
      .samples_in ({vote_reg[1:0], rx_s}),
      .high_out   (maj)
   ); // [R19]

   //*************************************************************
   // Sampling geometry
   //*************************************************************
   assign spb     = double_speed_select_reg ? `UXR_SPB_DBL : `UXR_SPB_NORM; // [R15] [R18]
   assign v_first = double_speed_select_reg ? `UXR_VOTE_DBL : `UXR_VOTE_NORM; // [R16]
   assign v_last  = v_first + `UXR_VOTE_SPAN;
   assign nbits   = {2'h0, char_size_reg} + `UXR_MIN_BITS;
   assign in_window = (cnt_reg >= v_first) && (cnt_reg <= v_last);
   assign is_data = (bit_reg < nbits);
   assign is_par  = (bit_reg == nbits) && parity_mode_field_reg[1]; // [R9]

   //*************************************************************
   // Clock and data recovery
   //*************************************************************
   always @* begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      bit_next   = bit_reg;
      vote_next  = vote_reg;
      shift_next = shift_reg;
      par_next   = par_reg;
      perr_next  = perr_reg;
      prev_next  = sample_tick_in ? rx_s : prev_reg;
      done       = 1'b0;
      start_ok   = 1'b0;
      done_fe    = 1'b0;
      if (!receiver_enable_reg) begin
         // Frame in flight is dropped; a high must be seen before a new edge
         state_next = ST_IDLE; // [R12]
         cnt_next   = 5'h00;
         prev_next  = 1'b0;
      end else if (sample_tick_in) begin
         case (state_reg)
            ST_IDLE: begin
               if (prev_reg && !rx_s) begin
                  state_next = ST_START;
                  cnt_next   = 5'h02; // [R16] edge tick is sample 1
               end
            end
            ST_START, ST_BITS: begin
               cnt_next = (cnt_reg == spb) ? 5'h01 : cnt_reg + 5'h01; // [R18]
               if (in_window) begin
                  vote_next = {vote_reg[1:0], rx_s};
               end
               if (cnt_reg == v_last) begin
                  if (state_reg == ST_START) begin
                     if (maj) begin
                        state_next = ST_IDLE; // [R17]
                     end else begin
                        start_ok   = 1'b1; // [R17]
                        shift_next = 8'h00;
                        par_next   = 1'b0;
                        perr_next  = 1'b0;
                        bit_next   = 4'h0;
                     end
                  end else if (is_data) begin
                     shift_next[bit_reg[2:0]] = maj; // [R19] [R20]
                     par_next = par_reg ^ maj;
                     bit_next = bit_reg + 4'h1;
                  end else if (is_par) begin
                     // Even: mismatch when total is odd; odd flips it
                     perr_next = par_reg ^ maj ^ parity_mode_field_reg[0]; // [R9]
                     bit_next  = bit_reg + 4'h1;
                  end else begin
                     // First stop bit ends the frame; later stops unseen
                     done    = 1'b1; // [R20]
                     done_fe = ~maj; // [R21] [R6]
                     // Double speed waits one sample longer before rearming
                     state_next = double_speed_select_reg ? ST_GAP : ST_IDLE; // [R22]
                  end
               end
               if ((cnt_reg == spb) && (state_reg == ST_START) && !maj) begin
                  state_next = ST_BITS;
               end
            end
            ST_GAP: begin
               state_next = ST_IDLE; // [R22]
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end
   end

   //*************************************************************
   // Receive buffer and waiting character
   //*************************************************************
   assign has_data = (fill_reg != 2'h0);
   // Status must be read first: this pop moves the head flags
   assign pop      = rd_in && (addr_in == `UXR_OFS_RX_DATA) && has_data; // [R2] [R14]
   assign can_push = (fill_reg != `UXR_BUF_DEPTH) || pop;
   assign head_fe  = has_data & mem_fe_reg[rptr_reg]; // [R1]
   assign head_dor = has_data & mem_dor_reg[rptr_reg]; // [R1]
   assign head_pe  = has_data & mem_pe_reg[rptr_reg] & parity_mode_field_reg[1]; // [R11]

   always @* begin
      push              = 1'b0;
      push_data         = hold_data_reg;
      push_fe           = hold_fe_reg;
      push_pe           = hold_pe_reg;
      hold_valid_next   = hold_valid_reg;
      hold_data_next    = hold_data_reg;
      hold_fe_next      = hold_fe_reg;
      hold_pe_next      = hold_pe_reg;
      overrun_flag_next = overrun_flag_reg;
      if (hold_valid_reg && can_push) begin
         push            = 1'b1;
         hold_valid_next = 1'b0;
      end
      if (done) begin
         if (!hold_valid_reg && can_push) begin
            push      = 1'b1;
            push_data = shift_reg;
            push_fe   = done_fe;
            push_pe   = perr_reg & parity_mode_field_reg[1]; // [R10]
         end else begin
            hold_valid_next = 1'b1;
            hold_data_next  = shift_reg;
            hold_fe_next    = done_fe;
            hold_pe_next    = perr_reg & parity_mode_field_reg[1]; // [R10]
         end
      end
      if (push) begin
         overrun_flag_next = 1'b0; // [R8]
      end
      // Waiting character is lost to the new frame; set beats clear
      if (start_ok && hold_valid_reg && !can_push) begin
         overrun_flag_next = 1'b1; // [R7]
         hold_valid_next   = 1'b0;
      end
      fill_next = fill_reg + {1'b0, push} - {1'b0, pop}; // [R23]
   end

   //*************************************************************
   // Read mux
   //*************************************************************
   // Error flags only polled here; no request line leaves the block [R5]
   always @* begin
      rdata_next = 8'h00;
      case (addr_in)
         `UXR_OFS_STATUS_A: begin
            rdata_next[`UXR_BIT_RXC] = has_data; // [R23]
            rdata_next[`UXR_BIT_FE]  = head_fe; // [R6]
            rdata_next[`UXR_BIT_DOR] = head_dor;
            rdata_next[`UXR_BIT_UPE] = head_pe; // [R10]
            rdata_next[`UXR_BIT_DBL] = double_speed_select_reg;
         end
         `UXR_OFS_CONTROL_B: begin
            rdata_next[`UXR_BIT_EN] = receiver_enable_reg;
         end
         `UXR_OFS_CONTROL_C: begin
            rdata_next[`UXR_BIT_UPM_HI:`UXR_BIT_UPM_LO] = parity_mode_field_reg;
            rdata_next[`UXR_BIT_SBS] = stop_bit_count_select_reg;
            rdata_next[`UXR_BIT_CSZ_HI:`UXR_BIT_CSZ_LO] = char_size_reg;
         end
         `UXR_OFS_RX_DATA: begin
            rdata_next = has_data ? mem_data_reg[rptr_reg] : 8'h00;
         end
         default: begin
            rdata_next = 8'h00;
         end
      endcase
   end

   //*************************************************************
   // Control registers
   //*************************************************************
   always @(posedge mclk_in) begin
      if (!rst_b_in) begin
         receiver_enable_reg       <= `UXR_RST_EN;
         double_speed_select_reg   <= `UXR_RST_DBL;
         parity_mode_field_reg     <= `UXR_RST_UPM;
         stop_bit_count_select_reg <= `UXR_RST_SBS;
         char_size_reg             <= `UXR_RST_CSZ;
         rdata_out                 <= 8'h00;
         pin_override_out          <= 1'b0;
      end else begin
         if (wr_in) begin
            case (addr_in)
               `UXR_OFS_STATUS_A: begin
                  // Flag bit positions are not stored at all
                  double_speed_select_reg <= wdata_in[`UXR_BIT_DBL]; // [R3] [R4]
               end
               `UXR_OFS_CONTROL_B: begin
                  receiver_enable_reg <= wdata_in[`UXR_BIT_EN];
               end
               `UXR_OFS_CONTROL_C: begin
                  parity_mode_field_reg <= wdata_in[`UXR_BIT_UPM_HI:`UXR_BIT_UPM_LO];
                  stop_bit_count_select_reg <= wdata_in[`UXR_BIT_SBS];
                  char_size_reg <= wdata_in[`UXR_BIT_CSZ_HI:`UXR_BIT_CSZ_LO];
               end
               default: begin
                  char_size_reg <= char_size_reg;
               end
            endcase
         end
         rdata_out        <= rd_in ? rdata_next : 8'h00;
         pin_override_out <= receiver_enable_reg; // [R12]
      end
   end

   //*************************************************************
   // Recovery state
   //*************************************************************
   always @(posedge mclk_in) begin
      if (!rst_b_in) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 5'h00;
         bit_reg   <= 4'h0;
         vote_reg  <= 3'h7;
         shift_reg <= 8'h00;
         par_reg   <= 1'b0;
         perr_reg  <= 1'b0;
         prev_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         bit_reg   <= bit_next;
         vote_reg  <= vote_next;
         shift_reg <= shift_next;
         par_reg   <= par_next;
         perr_reg  <= perr_next;
         prev_reg  <= prev_next;
      end
   end

   //*************************************************************
   // Buffer state
   //*************************************************************
   always @(posedge mclk_in) begin
      if (!rst_b_in || !receiver_enable_reg) begin
         // Disable throws away every unread character and its flags
         fill_reg         <= 2'h0; // [R13]
         rptr_reg         <= 1'b0;
         wptr_reg         <= 1'b0;
         hold_valid_reg   <= 1'b0;
         hold_data_reg    <= 8'h00;
         hold_fe_reg      <= 1'b0;
         hold_pe_reg      <= 1'b0;
         overrun_flag_reg <= 1'b0;
         mem_fe_reg       <= 2'h0;
         mem_dor_reg      <= 2'h0;
         mem_pe_reg       <= 2'h0;
         mem_data_reg[0]  <= 8'h00;
         mem_data_reg[1]  <= 8'h00;
      end else begin
         fill_reg         <= fill_next;
         hold_valid_reg   <= hold_valid_next;
         hold_data_reg    <= hold_data_next;
         hold_fe_reg      <= hold_fe_next;
         hold_pe_reg      <= hold_pe_next;
         overrun_flag_reg <= overrun_flag_next;
         if (pop) begin
            rptr_reg <= ~rptr_reg;
         end
         if (push) begin
            mem_data_reg[wptr_reg] <= push_data;
            mem_fe_reg[wptr_reg]   <= push_fe; // [R1]
            mem_dor_reg[wptr_reg]  <= overrun_flag_reg; // [R1]
            mem_pe_reg[wptr_reg]   <= push_pe; // [R1]
            wptr_reg               <= ~wptr_reg;
         end
      end
   end

endmodule // uxr_rx_core

// ==== uxr_rx_chk.sv ====
`include "uxr_defs.vh"

//****************************************************************
// Bus and pin checks
//****************************************************************
module uxr_rx_chk (
   input wire logic                   mclk_in,
   input wire logic                   rst_b_in,
   input wire logic [`UXR_ADDR_W-1:0] addr_in,
   input wire logic [7:0]             wdata_in,
   input wire logic                   wr_in,
   input wire logic                   rd_in,
   input wire logic                   sample_tick_in,
   input wire logic                   serial_input_pin_in,
   input wire logic [7:0]             rdata_out,
   input wire logic                   pin_override_out
);
   logic en_q;
   logic par_q;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   // Control shadows, known only from the writes seen
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         en_q  <= 1'b0;
         par_q <= 1'b0;
      end else begin
         if (wr_in && addr_in == `UXR_OFS_CONTROL_B) en_q <= wdata_in[`UXR_BIT_EN];
         if (wr_in && addr_in == `UXR_OFS_CONTROL_C) par_q <= wdata_in[`UXR_BIT_UPM_HI];
      end
   end
   sequence s_rd_stat;
      rd_in && addr_in == `UXR_OFS_STATUS_A;
   endsequence
   sequence s_wr_stat;
      wr_in && addr_in == `UXR_OFS_STATUS_A;
   endsequence
   sequence s_rd_data;
      rd_in && addr_in == `UXR_OFS_RX_DATA;
   endsequence
   sequence s_wr_en(v);
      wr_in && addr_in == `UXR_OFS_CONTROL_B && wdata_in[`UXR_BIT_EN] == v;
   endsequence
   a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside its slot");
   a_en_on: assert property (s_wr_en(1'b1) |-> ##[1:2] pin_override_out)
      else $error("pin not taken after enable");
   a_dis_fast: assert property (s_wr_en(1'b0) |-> ##[1:2] !pin_override_out)
      else $error("pin not released after disable");
   a_pin_follows_en: assert property (en_q == $past(en_q) |-> pin_override_out == en_q)
      else $error("pin ownership differs from enable");
   a_disable_flush: assert property (s_wr_en(1'b0) ##2 s_rd_stat |=>
      rdata_out[7] == 1'b0 && rdata_out[4:2] == 3'h0) else $error("buffer kept after disable");
   a_parity_off: assert property (s_rd_stat and !par_q |=> !rdata_out[`UXR_BIT_UPE])
      else $error("parity flag with checking off");
   a_flag_wr_keep: assert property (s_rd_stat ##2 s_wr_stat ##2 s_rd_stat |=>
      rdata_out[4:2] == $past(rdata_out[4:2], 4)) else $error("flags altered by write");
   a_empty_zero: assert property (s_rd_stat ##1 !rdata_out[7] ##1 s_rd_data |=>
      rdata_out == 8'h00) else $error("data from empty buffer");
endmodule // uxr_rx_chk

bind uxr_rx_core uxr_rx_chk u_chk (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .sample_tick_in(sample_tick_in), .serial_input_pin_in(serial_input_pin_in),
   .rdata_out(rdata_out), .pin_override_out(pin_override_out));

// ==== uxr_tx_model.sv ====
//****************************************************************
// Remote serial sender, paced by the oversample ticks
//****************************************************************
module uxr_tx_model (
   input  wire logic mclk_in,
   input  wire logic sample_tick_in,
   output logic      line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int spb = 16;
   time t_tick = 0;
   initial line_out = 1'b1;
   // Idle level is high, as a pulled-up line would sit
   // Changes land on a tick edge, else the receiver sees a cell one sample short
   task automatic hold(input logic v, input int n);
      if ($time != t_tick) begin
         do @(posedge mclk_in); while (sample_tick_in !== 1'b1);
      end
      line_out <= v;
      repeat (n) begin
         do @(posedge mclk_in); while (sample_tick_in !== 1'b1);
      end
      t_tick = $time;
   endtask
   // Short stop length lets the next start come early
   task automatic send(input logic [7:0] d, input int nb, input logic pe,
                       input logic pv, input logic stp, input int sl);
      hold(1'b0, spb);
      for (int i = 0; i < nb; i++) hold(d[i], spb);
      if (pe) hold(pv, spb);
      hold(stp, sl);
   endtask
endmodule // uxr_tx_model

// ==== tb.sv ====
`include "uxr_defs.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [1:0] SA = `UXR_OFS_STATUS_A, CB = `UXR_OFS_CONTROL_B;
   localparam logic [1:0] CC = `UXR_OFS_CONTROL_C, DR = `UXR_OFS_RX_DATA;
   logic       mclk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
   logic       sample_tick_in = 1'b0;
   logic [1:0] addr_in = 2'h0, tick_cnt = 2'h0;
   logic [7:0] wdata_in = 8'h00;
   wire        serial_input_pin_in, pin_override_out;
   wire  [7:0] rdata_out;
   int         n_mismatch = 0, samples_checked = 0;

   uxr_rx_core dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .sample_tick_in(sample_tick_in),
      .serial_input_pin_in(serial_input_pin_in), .rdata_out(rdata_out),
      .pin_override_out(pin_override_out));
   uxr_tx_model tx (.mclk_in(mclk_in), .sample_tick_in(sample_tick_in),
      .line_out(serial_input_pin_in));

   always #50 mclk_in = ~mclk_in;
   // One tick every fourth clock, clear of the synchroniser delay
   always @(posedge mclk_in) begin
      tick_cnt <= tick_cnt + 2'h1;
      sample_tick_in <= (tick_cnt == 2'h3);
   end

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1;
      `CHK("read data", e, rdata_out)
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic t_basic;
      rd(CC, 8'h06);
      rd(SA, 8'h00);
      wr(CB, 8'h10);
      tx.hold(1'b1, 10);
      tx.hold(1'b0, 8);
      tx.hold(1'b1, 40);
      rd(SA, 8'h00);
      tx.send(8'ha5, 8, 1'b0, 1'b0, 1'b1, 10);
      tx.send(8'h5a, 8, 1'b0, 1'b0, 1'b1, 16);
      rd(SA, 8'h80);
      rd(DR, 8'ha5);
      rd(SA, 8'h80);
      rd(DR, 8'h5a);
   endtask
   task automatic t_overrun;
      for (int i = 1; i < 5; i++) tx.send(8'(i * 17), 8, 1'b0, 1'b0, 1'b1, 16);
      rd(SA, 8'h80);
      rd(DR, 8'h11);
      rd(SA, 8'h80);
      rd(DR, 8'h22);
      rd(SA, 8'h88);
      rd(DR, 8'h44);
      rd(SA, 8'h00);
      rd(DR, 8'h00);
   endtask
   task automatic t_frame;
      wr(CC, 8'h0e);
      tx.send(8'h5a, 8, 1'b0, 1'b0, 1'b0, 16);
      tx.hold(1'b1, 16);
      rd(SA, 8'h90);
      wr(SA, 8'h00);
      rd(SA, 8'h90);
      rd(DR, 8'h5a);
   endtask
   task automatic t_parity;
      logic [7:0] d;
      logic       odd;
      logic       bad;
      for (int m = 0; m < 5; m++) begin
         d = 8'h3c + 8'(m);
         odd = m[1];
         bad = m[0] | m[2];
         wr(CC, {3'b001, odd, 4'h6});
         tx.send(d, 8, 1'b1, ^d ^ odd ^ bad, 1'b1, 16);
         if (m == 4) wr(CC, 8'h06);
         rd(SA, {5'h10, bad & (m < 4), 2'h0});
         rd(DR, d);
      end
      wr(CC, 8'h00);
      tx.send(8'hff, 5, 1'b0, 1'b0, 1'b1, 16);
      rd(SA, 8'h80);
      rd(DR, 8'h1f);
      wr(CC, 8'h06);
   endtask
   task automatic t_disable;
      tx.send(8'h77, 8, 1'b0, 1'b0, 1'b1, 16);
      fork
         tx.send(8'h99, 8, 1'b0, 1'b0, 1'b1, 16);
         begin
            repeat (200) @(posedge mclk_in);
            wr(CB, 8'h00);
            rd(SA, 8'h00);
            `CHK("pin owner", 1'b0, pin_override_out)
         end
      join
      wr(CB, 8'h10);
      repeat (40) @(posedge mclk_in);
      rd(SA, 8'h00);
      `CHK("pin owner", 1'b1, pin_override_out)
   endtask
   task automatic t_dbl;
      wr(SA, 8'h02);
      tx.spb = 8;
      tx.send(8'hc3, 8, 1'b0, 1'b0, 1'b1, 7);
      tx.send(8'h3c, 8, 1'b0, 1'b0, 1'b1, 8);
      rd(SA, 8'h82);
      rd(DR, 8'hc3);
      rd(SA, 8'h82);
      rd(DR, 8'h3c);
   endtask

   initial begin
      repeat (8) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      t_basic;
      t_overrun;
      t_frame;
      t_parity;
      t_disable;
      t_dbl;
      finish_test;
   end
   // About five times the expected run
   initial begin
      #5000000;
      n_mismatch++;
      finish_test;
   end
endmodule // tb
